// [logic/instr_decode.sv]
// Instruction fetch, decode and execution timing for the accumulator core.
// Assumes program memory hands bytes over a valid/ready pair and that the
// datapath acts on the decoded fields while o_busy is high.
`include "idec_map.svh"

module instr_decode
    import idec_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Program memory byte stream
    input wire logic i_code_valid,
    input wire logic [7:0] i_code_byte,
    output logic o_code_ready,
    // Decoded instruction
    output logic o_dec_valid,
    output logic o_unsupported,
    output logic [7:0] o_opcode,
    output op_class_e o_op_class,
    output addr_mode_e o_src_mode,
    output addr_mode_e o_dst_mode,
    output logic [1:0] o_length,
    output logic [3:0] o_cycles,
    output logic [2:0] o_reg_num,
    output logic o_ptr_sel,
    output logic [7:0] o_operand1,
    output logic [7:0] o_operand2,
    // Execution phase
    output logic o_busy,
    output logic o_done,
    // Memory side strobes, level for the whole execution phase
    output logic o_code_rd,
    output logic o_ext_rd,
    output logic o_ext_wr,
    output logic o_ext_wide
);

    typedef enum logic [1:0] {
        ST_OPCODE, ST_BYTE2, ST_BYTE3, ST_EXEC
    } state_e;

    function automatic dec_s mk(input op_class_e c, input addr_mode_e s,
                                input addr_mode_e d, input logic [1:0] l,
                                input logic [3:0] n);
        dec_s r;
        r.cls = c;
        r.src = s;
        r.dst = d;
        r.len = l;
        r.cyc = n;
        mk = r;
    endfunction

    function automatic op_class_e alu_class(input logic [3:0] hi);
        case (hi)
            `GRP_ADD: alu_class = OP_ADD;
            `GRP_ADDC: alu_class = OP_ADDC;
            `GRP_SUBB: alu_class = OP_SUBB;
            `GRP_ANL: alu_class = OP_ANL;
            `GRP_ORL: alu_class = OP_ORL;
            `GRP_XRL: alu_class = OP_XRL;
            default: alu_class = OP_UNSUP;
        endcase
    endfunction

    // Accumulator forms shared by all six arithmetic and logic groups
    function automatic dec_s alu_form(input logic [7:0] op);
        op_class_e c;
        c = alu_class(op[7:4]);
        if (op[3]) begin
            alu_form = mk(c, AM_REG, AM_ACC, `LEN_1, `CYC_SHORT);
        end else if (op[3:1] == 3'h3) begin
            alu_form = mk(c, AM_INDIRECT, AM_ACC, `LEN_1, `CYC_SHORT);
        end else if (op[3:0] == `FORM_DIR) begin
            alu_form = mk(c, AM_DIRECT, AM_ACC, `LEN_2, `CYC_SHORT);
        end else begin
            alu_form = mk(c, AM_IMM, AM_ACC, `LEN_2, `CYC_SHORT);
        end
    endfunction

    function automatic dec_s decode_op(input logic [7:0] op);
        logic alu_grp;
        logic logic_grp;
        dec_s d;
        alu_grp = (alu_class(op[7:4]) != OP_UNSUP);
        logic_grp = (op[7:4] == `GRP_ANL) || (op[7:4] == `GRP_ORL) ||
                    (op[7:4] == `GRP_XRL);
        d = mk(OP_UNSUP, AM_NONE, AM_NONE, `LEN_1, `CYC_UNSUP);
        if (alu_grp && op[3:0] >= `FORM_IMM) begin
            d = alu_form(op);
        end else if (logic_grp && op[3:0] == `FORM_DIR_A) begin
            d = mk(alu_class(op[7:4]), AM_ACC, AM_DIRECT, `LEN_2,
                   `CYC_SHORT);
        end else if (logic_grp && op[3:0] == `FORM_DIR_IMM) begin
            d = mk(alu_class(op[7:4]), AM_IMM, AM_DIRECT, `LEN_3,
                   `CYC_LONG);
        end else begin
            casez (op)
                `OPC_RL: d = mk(OP_ROT_L, AM_ACC, AM_ACC, `LEN_1,
                                `CYC_SHORT);
                `OPC_RLC: d = mk(OP_ROT_LC, AM_ACC, AM_ACC, `LEN_1,
                                 `CYC_SHORT);
                `OPC_RR: d = mk(OP_ROT_R, AM_ACC, AM_ACC, `LEN_1,
                                `CYC_SHORT);
                `OPC_RRC: d = mk(OP_ROT_RC, AM_ACC, AM_ACC, `LEN_1,
                                 `CYC_SHORT);
                `OPC_MOV_DD: d = mk(OP_MOV, AM_DIRECT, AM_DIRECT, `LEN_3,
                                    `CYC_LONG);
                `OPC_MOV_REG_DIR: d = mk(OP_MOV, AM_DIRECT, AM_REG, `LEN_2,
                                         `CYC_LONG);
                `OPC_MOV_REG_IMM: d = mk(OP_MOV, AM_IMM, AM_REG, `LEN_2,
                                         `CYC_SHORT);
                `OPC_MOV_DIR_REG: d = mk(OP_MOV, AM_REG, AM_DIRECT, `LEN_2,
                                         `CYC_LONG);
                `OPC_MOV_DIR_A: d = mk(OP_MOV, AM_ACC, AM_DIRECT, `LEN_2,
                                       `CYC_SHORT);
                `OPC_LOAD_PTR: d = mk(OP_LOAD_PTR, AM_IMM, AM_PTR16, `LEN_3,
                                      `CYC_LONG);
                `OPC_CODE_PTR: d = mk(OP_CODE_RD, AM_CODE_PTR, AM_ACC,
                                      `LEN_1, `CYC_MEM);
                `OPC_CODE_PC: d = mk(OP_CODE_RD, AM_CODE_PC, AM_ACC,
                                     `LEN_1, `CYC_MEM);
                `OPC_EXT_RD16: d = mk(OP_EXT_RD, AM_EXT16, AM_ACC, `LEN_1,
                                      `CYC_MEM);
                `OPC_EXT_RD8: d = mk(OP_EXT_RD, AM_EXT8, AM_ACC, `LEN_1,
                                     `CYC_MEM);
                `OPC_EXT_WR16: d = mk(OP_EXT_WR, AM_ACC, AM_EXT16, `LEN_1,
                                      `CYC_MEM);
                `OPC_EXT_WR8: d = mk(OP_EXT_WR, AM_ACC, AM_EXT8, `LEN_1,
                                     `CYC_MEM);
                `OPC_MOV_IND_IMM: d = mk(OP_MOV, AM_IMM, AM_INDIRECT,
                                         `LEN_2, `CYC_SHORT);
                `OPC_MOV_IND_DIR: d = mk(OP_MOV, AM_DIRECT, AM_INDIRECT,
                                         `LEN_2, `CYC_LONG);
                `OPC_MOV_IND_A: d = mk(OP_MOV, AM_ACC, AM_INDIRECT,
                                       `LEN_1, `CYC_SHORT);
                `OPC_POP: d = mk(OP_POP, AM_STACK, AM_DIRECT, `LEN_2,
                                 `CYC_LONG);
                `OPC_PUSH: d = mk(OP_PUSH, AM_DIRECT, AM_STACK, `LEN_2,
                                  `CYC_LONG);
                `OPC_XCH_REG: d = mk(OP_XCH, AM_REG, AM_ACC, `LEN_1,
                                    `CYC_SHORT);
                `OPC_XCH_DIR: d = mk(OP_XCH, AM_DIRECT, AM_ACC, `LEN_2,
                                     `CYC_SHORT);
                `OPC_XCH_IND: d = mk(OP_XCH, AM_INDIRECT, AM_ACC, `LEN_1,
                                     `CYC_SHORT);
                `OPC_XCH_LOW: d = mk(OP_XCH_LOW, AM_INDIRECT, AM_ACC, `LEN_1,
                                  `CYC_SHORT);
                `OPC_ANL_C: d = mk(OP_ANL_C, AM_BIT, AM_CARRY, `LEN_2,
                                   `CYC_LONG);
                `OPC_ANL_NC: d = mk(OP_ANL_NC, AM_BIT, AM_CARRY, `LEN_2,
                                    `CYC_LONG);
                `OPC_ORL_C: d = mk(OP_ORL_C, AM_BIT, AM_CARRY, `LEN_2,
                                   `CYC_LONG);
                `OPC_ORL_NC: d = mk(OP_ORL_NC, AM_BIT, AM_CARRY, `LEN_2,
                                    `CYC_LONG);
                `OPC_MOV_C_BIT: d = mk(OP_MOV_C, AM_BIT, AM_CARRY, `LEN_2,
                                       `CYC_SHORT);
                `OPC_MOV_BIT_C: d = mk(OP_MOV_C, AM_CARRY, AM_BIT, `LEN_2,
                                       `CYC_LONG);
                default: d = mk(OP_UNSUP, AM_NONE, AM_NONE, `LEN_1,
                                `CYC_UNSUP);
            endcase
        end
        decode_op = d;
    endfunction

    state_e state;
    state_e next_state;
    dec_s tbl;
    logic take;
    logic take_op;
    logic take_b2;
    logic take_b3;
    logic last_byte;
    op_class_e cur_cls;
    addr_mode_e cur_src;
    addr_mode_e cur_dst;
    logic [3:0] start_cycles;
    logic cur_wide;
    logic [2:0] fld_reg;
    logic fld_ptr;
    logic next_code_rd;
    logic next_ext_rd;
    logic next_ext_wr;
    logic next_ext_wide;

    assign tbl = decode_op(i_code_byte);
    assign take = o_code_ready && i_code_valid;
    assign take_op = take && (state == ST_OPCODE);
    assign take_b2 = take && (state == ST_BYTE2);
    assign take_b3 = take && (state == ST_BYTE3);
    // A one-byte opcode starts execution in the cycle it is taken
    assign last_byte = (take_op && tbl.len == `LEN_1) ||
                       (take_b2 && o_length == `LEN_2) || take_b3;
    assign cur_cls = take_op ? tbl.cls : o_op_class;
    assign cur_src = take_op ? tbl.src : o_src_mode;
    assign cur_dst = take_op ? tbl.dst : o_dst_mode;
    assign start_cycles = take_op ? tbl.cyc : o_cycles;
    assign cur_wide = (cur_src == AM_EXT16) || (cur_dst == AM_EXT16);

    // Strobes rise with the start and drop after the final cycle
    assign next_code_rd = last_byte ? (cur_cls == OP_CODE_RD) :
                          (o_done ? 1'b0 : o_code_rd);
    assign next_ext_rd = last_byte ? (cur_cls == OP_EXT_RD) :
                         (o_done ? 1'b0 : o_ext_rd);
    assign next_ext_wr = last_byte ? (cur_cls == OP_EXT_WR) :
                         (o_done ? 1'b0 : o_ext_wr);
    assign next_ext_wide = last_byte ? cur_wide :
                           (o_done ? 1'b0 : o_ext_wide);

    always_comb begin
        next_state = state;
        case (state)
            ST_OPCODE: begin
                if (take) begin
                    next_state = last_byte ? ST_EXEC : ST_BYTE2;
                end
            end
            ST_BYTE2: begin
                if (take) begin
                    next_state = last_byte ? ST_EXEC : ST_BYTE3;
                end
            end
            ST_BYTE3: begin
                if (take) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (o_done) begin
                    next_state = ST_OPCODE;
                end
            end
            default: next_state = ST_OPCODE;
        endcase
    end

    operand_field i_operand_field (
        .i_opcode(i_code_byte),
        .i_src_mode(tbl.src),
        .i_dst_mode(tbl.dst),
        .o_reg_num(fld_reg),
        .o_ptr_sel(fld_ptr)
    );

    exec_timer i_exec_timer (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_start(last_byte),
        .i_cycles(start_cycles),
        .o_busy(o_busy),
        .o_last(o_done)
    );

    // Fetch is held off for the whole execution phase
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state <= ST_OPCODE;
            o_code_ready <= 1'b0;
            o_dec_valid <= 1'b0;
            o_unsupported <= 1'b0;
            o_code_rd <= 1'b0;
            o_ext_rd <= 1'b0;
            o_ext_wr <= 1'b0;
            o_ext_wide <= 1'b0;
        end else begin
            state <= next_state;
            o_code_ready <= (next_state != ST_EXEC);
            o_dec_valid <= last_byte;
            o_unsupported <= last_byte && (cur_cls == OP_UNSUP);
            o_code_rd <= next_code_rd;
            o_ext_rd <= next_ext_rd;
            o_ext_wr <= next_ext_wr;
            o_ext_wide <= next_ext_wide;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_opcode <= `RST_OPCODE;
            o_op_class <= OP_UNSUP;
            o_src_mode <= AM_NONE;
            o_dst_mode <= AM_NONE;
            o_length <= `LEN_1;
            o_cycles <= `CYC_UNSUP;
            o_reg_num <= 3'h0;
            o_ptr_sel <= 1'b0;
        end else if (take_op) begin
            o_opcode <= i_code_byte;
            o_op_class <= tbl.cls;
            o_src_mode <= tbl.src;
            o_dst_mode <= tbl.dst;
            o_length <= tbl.len;
            o_cycles <= tbl.cyc;
            o_reg_num <= fld_reg;
            o_ptr_sel <= fld_ptr;
        end
    end

    // Operand bytes keep old values for shorter instructions
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_operand1 <= 8'h00;
            o_operand2 <= 8'h00;
        end else begin
            if (take_b2) begin
                o_operand1 <= i_code_byte;
            end
            if (take_b3) begin
                o_operand2 <= i_code_byte;
            end
        end
    end

    no_fetch_busy_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_busy |-> !o_code_ready)
        else $error("fetch ready during execution");

    done_reopen_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_done |=> o_code_ready && !o_busy && !o_done)
        else $error("fetch not reopened after last cycle");

    add_two_cyc_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_dec_valid && o_op_class == OP_ADD |->
            o_busy [*2] ##1 !o_busy)
        else $error("add did not take two cycles");

    anl_imm_dir_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_dec_valid && o_opcode == {`GRP_ANL, `FORM_DIR_IMM} |->
            o_length == `LEN_3 && o_busy [*4] ##1 !o_busy)
        else $error("and immediate to direct timing wrong");

    pointer_load_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_dec_valid && o_opcode == `OPC_LOAD_PTR |->
            o_length == `LEN_3 && o_cycles == `CYC_LONG &&
            o_dst_mode == AM_PTR16)
        else $error("data pointer load decoded wrong");

    code_read_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_dec_valid && o_op_class == OP_CODE_RD |->
            (o_busy && o_code_rd) [*8] ##1 !o_busy && !o_code_rd)
        else $error("code memory read not eight cycles");

    ext_read_wide_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_dec_valid && o_opcode == `OPC_EXT_RD16 |->
            o_ext_rd && o_ext_wide && !o_ext_wr)
        else $error("wide external read strobes wrong");

    ext_write_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_dec_valid && (o_opcode ==? `OPC_EXT_WR8) |->
            (o_ext_wr && !o_ext_wide) [*8] ##1 !o_ext_wr)
        else $error("narrow external write strobes wrong");

    reg_number_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_dec_valid && (o_src_mode == AM_REG || o_dst_mode == AM_REG)
            |-> o_reg_num == o_opcode[2:0])
        else $error("register number not from opcode");

    pointer_sel_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_dec_valid && (o_src_mode == AM_INDIRECT ||
            o_dst_mode == AM_INDIRECT) |-> o_ptr_sel == o_opcode[0])
        else $error("pointer select not from opcode bit 0");

endmodule // instr_decode

// [logic/idec_map.svh]
// Opcode patterns, lengths and cycle counts of the instruction decoder.
// Definitions only; included by the instr_decode module alone.
`ifndef IDEC_MAP_SVH
`define IDEC_MAP_SVH

`define RST_OPCODE 8'h00
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3
`define CYC_UNSUP 4'h1
`define CYC_SHORT 4'h2
`define CYC_LONG 4'h4
`define CYC_MEM 4'h8

// Arithmetic and logic groups: high nibble picks the operation
`define GRP_ADD 4'h2
`define GRP_ADDC 4'h3
`define GRP_ORL 4'h4
`define GRP_ANL 4'h5
`define GRP_XRL 4'h6
`define GRP_SUBB 4'h9
// Low nibble picks the operand form
`define FORM_DIR_A 4'h2
`define FORM_DIR_IMM 4'h3
`define FORM_IMM 4'h4
`define FORM_DIR 4'h5

`define OPC_RL 8'h23
`define OPC_RLC 8'h33
`define OPC_RR 8'h03
`define OPC_RRC 8'h13
`define OPC_MOV_DD 8'h85
`define OPC_MOV_REG_DIR 8'b1010_1???
`define OPC_MOV_REG_IMM 8'b0111_1???
`define OPC_MOV_DIR_REG 8'b1000_1???
`define OPC_MOV_DIR_A 8'hf5
`define OPC_LOAD_PTR 8'h90
`define OPC_CODE_PTR 8'h93
`define OPC_CODE_PC 8'h83
`define OPC_EXT_RD16 8'he0
`define OPC_EXT_RD8 8'b1110_001?
`define OPC_EXT_WR16 8'hf0
`define OPC_EXT_WR8 8'b1111_001?
`define OPC_MOV_IND_IMM 8'b0111_011?
`define OPC_MOV_IND_DIR 8'b1010_011?
`define OPC_MOV_IND_A 8'b1111_011?
`define OPC_POP 8'hd0
`define OPC_PUSH 8'hc0
`define OPC_XCH_REG 8'b1100_1???
`define OPC_XCH_DIR 8'hc5
`define OPC_XCH_IND 8'b1100_011?
`define OPC_XCH_LOW 8'b1101_011?
`define OPC_ANL_C 8'h82
`define OPC_ANL_NC 8'hb0
`define OPC_ORL_C 8'h72
`define OPC_ORL_NC 8'ha0
`define OPC_MOV_C_BIT 8'ha2
`define OPC_MOV_BIT_C 8'h92

`endif

// [logic/idec_pkg.sv]
// Types shared by the instruction decoder files.
// Assumes nothing of its surroundings.
package idec_pkg;

    typedef enum logic [4:0] {
        OP_UNSUP, OP_ADD, OP_ADDC, OP_SUBB, OP_ANL, OP_ORL, OP_XRL,
        OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC, OP_MOV, OP_LOAD_PTR,
        OP_CODE_RD, OP_EXT_RD, OP_EXT_WR, OP_PUSH, OP_POP, OP_XCH,
        OP_XCH_LOW, OP_ANL_C, OP_ANL_NC, OP_ORL_C, OP_ORL_NC, OP_MOV_C
    } op_class_e;

    typedef enum logic [3:0] {
        AM_NONE, AM_ACC, AM_REG, AM_DIRECT, AM_INDIRECT, AM_IMM,
        AM_PTR16, AM_CODE_PTR, AM_CODE_PC, AM_EXT8, AM_EXT16, AM_BIT,
        AM_CARRY, AM_STACK
    } addr_mode_e;

    typedef struct packed {
        op_class_e cls;
        addr_mode_e src;
        addr_mode_e dst;
        logic [1:0] len;
        logic [3:0] cyc;
    } dec_s;

endpackage

// [logic/exec_timer.sv]
// Execution phase counter: holds busy for a given number of cycles.
// Started by the decoder on the cycle the last instruction byte is taken.
module exec_timer
    import idec_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Start request
    input wire logic i_start,
    input wire logic [3:0] i_cycles,
    // Phase
    output logic o_busy,
    output logic o_last
);

    logic [3:0] remain;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            remain <= 4'h0;
            o_busy <= 1'b0;
            o_last <= 1'b0;
        end else if (i_start) begin
            remain <= i_cycles - 4'h1;
            o_busy <= 1'b1;
            o_last <= (i_cycles == 4'h1);
        end else if (o_busy) begin
            remain <= remain - 4'h1;
            o_last <= (remain == 4'h1);
            o_busy <= !o_last;
        end
    end

endmodule // exec_timer

// [logic/operand_field.sv]
// Register number and pointer select taken from the opcode's low bits.
// Pure decode; the caller registers the results.
module operand_field
    import idec_pkg::*;
(
    // Decoded opcode
    input wire logic [7:0] i_opcode,
    input wire addr_mode_e i_src_mode,
    input wire addr_mode_e i_dst_mode,
    // Fields
    output logic [2:0] o_reg_num,
    output logic o_ptr_sel
);

    function automatic logic uses(input addr_mode_e a, input addr_mode_e b,
                                  input addr_mode_e m);
        uses = (a == m) || (b == m);
    endfunction

    logic uses_reg;
    logic uses_ptr;
    assign uses_reg = uses(i_src_mode, i_dst_mode, AM_REG);
    assign uses_ptr = uses(i_src_mode, i_dst_mode, AM_INDIRECT) ||
                      uses(i_src_mode, i_dst_mode, AM_EXT8);
    // Unused fields read zero so stale bits never look meaningful
    assign o_reg_num = uses_reg ? i_opcode[2:0] : 3'h0;
    assign o_ptr_sel = uses_ptr ? i_opcode[0] : 1'b0;

endmodule // operand_field

// [bench/code_feeder.sv]
// Program memory model: hands queued bytes to the decoder in order.
// Assumes a byte is taken at an edge with valid and ready both high.
module code_feeder (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Byte stream
    input wire logic i_code_ready,
    output logic o_code_valid,
    output logic [7:0] o_code_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q [$];
    initial begin
        o_code_valid = 1'b0;
        o_code_byte = 8'h00;
    end
    always @(posedge i_sys_clk) begin
        if (!i_srst && o_code_valid && i_code_ready) begin
            void'(q.pop_front());
        end
        // Idle byte keeps toggling so a stale value never looks valid
        if (!i_srst && q.size() > 0) begin
            o_code_valid <= 1'b1;
            o_code_byte <= q[0];
        end else begin
            o_code_valid <= 1'b0;
            o_code_byte <= ~o_code_byte;
        end
    end
endmodule // code_feeder

// [bench/instr_decode_tb.sv]
// Self-checking bench for the instruction decoder.
// Assumes code_feeder supplies the bytes queued by each scenario.
module instr_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import idec_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic v, rdy, dv, uns, busy, done, crd, erd, ewr, ew, ps;
    logic [7:0] b, opc, op1, op2;
    logic [1:0] len;
    logic [3:0] cyc;
    logic [2:0] rn;
    op_class_e cls;
    addr_mode_e sm;
    addr_mode_e dm;
    int err_total = 0;
    int tests_run = 0;
    instr_decode i_instr_decode (.i_sys_clk(clk), .i_srst(rst),
        .i_code_valid(v), .i_code_byte(b), .o_code_ready(rdy),
        .o_dec_valid(dv), .o_unsupported(uns), .o_opcode(opc),
        .o_op_class(cls), .o_src_mode(sm), .o_dst_mode(dm), .o_length(len),
        .o_cycles(cyc), .o_reg_num(rn), .o_ptr_sel(ps), .o_operand1(op1),
        .o_operand2(op2), .o_busy(busy), .o_done(done), .o_code_rd(crd),
        .o_ext_rd(erd), .o_ext_wr(ewr), .o_ext_wide(ew));
    code_feeder i_code_feeder (.i_sys_clk(clk), .i_srst(rst),
        .i_code_ready(rdy), .o_code_valid(v), .o_code_byte(b));
    always #5 clk = ~clk;
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // Last argument is the expected {code_rd, ext_rd, ext_wr, ext_wide}
    task automatic run_op(logic [7:0] o, logic [1:0] l, logic [3:0] c,
                          logic [3:0] s);
        int n;
        i_code_feeder.q.push_back(o);
        if (l > 1) i_code_feeder.q.push_back(8'h5a);
        if (l > 2) i_code_feeder.q.push_back(8'ha5);
        n = 0;
        while (dv !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        chk("opcode", o, opc);
        chk("length", l, len);
        chk("cycles", c, cyc);
        chk("unsup", o == 8'h00, uns);
        chk("strobes", s, {crd, erd, ewr, ew});
        if (l > 1) chk("operand1", 8'h5a, op1);
        if (l > 2) chk("operand2", 8'ha5, op2);
        n = 0;
        while (busy === 1'b1 && n < 12) begin
            n++;
            chk("done", n == c, done);
            @(posedge clk);
            #1;
        end
        chk("busy_len", c, n);
    endtask
    task automatic t_unsup;
        run_op(8'h00, 1, 1, 0);
    endtask
    task automatic t_alu;
        logic [3:0] g [6] = '{4'h2, 4'h3, 4'h9, 4'h5, 4'h4, 4'h6};
        op_class_e k [6] = '{OP_ADD, OP_ADDC, OP_SUBB,
                             OP_ANL, OP_ORL, OP_XRL};
        foreach (g[i]) begin
            run_op({g[i], 4'hd}, 1, 2, 0);
            chk("reg_num", 5, rn);
            chk("class", k[i], cls);
            chk("src_mode", AM_REG, sm);
            run_op({g[i], 4'h5}, 2, 2, 0);
            run_op({g[i], 4'h7}, 1, 2, 0);
            chk("ptr_sel", 1, ps);
            chk("src_mode", AM_INDIRECT, sm);
            run_op({g[i], 4'h4}, 2, 2, 0);
            if (i > 2) run_op({g[i], 4'h2}, 2, 2, 0);
            if (i > 2) run_op({g[i], 4'h3}, 3, 4, 0);
            if (i > 2) chk("dst_mode", AM_DIRECT, dm);
        end
    endtask
    task automatic t_rot;
        run_op(8'h23, 1, 2, 0);
        chk("class", OP_ROT_L, cls);
        run_op(8'h33, 1, 2, 0);
        run_op(8'h03, 1, 2, 0);
        run_op(8'h13, 1, 2, 0);
        chk("class", OP_ROT_RC, cls);
    endtask
    task automatic t_move;
        run_op(8'h85, 3, 4, 0);
        run_op(8'ha8, 2, 4, 0);
        run_op(8'h7f, 2, 2, 0);
        chk("reg_num", 7, rn);
        run_op(8'h8a, 2, 4, 0);
        run_op(8'hf5, 2, 2, 0);
        run_op(8'h90, 3, 4, 0);
        chk("dst_mode", AM_PTR16, dm);
        run_op(8'h76, 2, 2, 0);
        chk("ptr_sel", 0, ps);
        run_op(8'ha7, 2, 4, 0);
        run_op(8'hf6, 1, 2, 0);
        run_op(8'hd0, 2, 4, 0);
        chk("class", OP_POP, cls);
        run_op(8'hc0, 2, 4, 0);
        chk("class", OP_PUSH, cls);
        run_op(8'hc8, 1, 2, 0);
        run_op(8'hc5, 2, 2, 0);
        run_op(8'hc6, 1, 2, 0);
        run_op(8'hd7, 1, 2, 0);
        chk("class", OP_XCH_LOW, cls);
        run_op(8'h82, 2, 4, 0);
        run_op(8'hb0, 2, 4, 0);
        chk("class", OP_ANL_NC, cls);
        run_op(8'h72, 2, 4, 0);
        run_op(8'ha0, 2, 4, 0);
        run_op(8'ha2, 2, 2, 0);
        run_op(8'h92, 2, 4, 0);
        chk("dst_mode", AM_BIT, dm);
    endtask
    task automatic t_ext;
        run_op(8'h93, 1, 8, 4'h8);
        chk("src_mode", AM_CODE_PTR, sm);
        run_op(8'h83, 1, 8, 4'h8);
        chk("src_mode", AM_CODE_PC, sm);
        run_op(8'he0, 1, 8, 4'h5);
        run_op(8'he3, 1, 8, 4'h4);
        chk("src_mode", AM_EXT8, sm);
        chk("ptr_sel", 1, ps);
        run_op(8'hf0, 1, 8, 4'h3);
        chk("dst_mode", AM_EXT16, dm);
        run_op(8'hf2, 1, 8, 4'h2);
    endtask
    // Reset in mid execution must drop the strobes and reopen fetch
    task automatic t_reset;
        int n;
        i_code_feeder.q.push_back(8'h93);
        n = 0;
        while (dv !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        chk("code_rd", 1, crd);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("rst_busy", 0, busy);
        chk("rst_ready", 0, rdy);
        chk("rst_code_rd", 0, crd);
        chk("rst_opcode", 8'h00, opc);
        chk("rst_length", 1, len);
        chk("rst_cycles", 1, cyc);
        chk("rst_class", OP_UNSUP, cls);
        chk("rst_operand1", 8'h00, op1);
        @(posedge clk);
        #1;
        chk("ready_back", 1, rdy);
        chk("busy_idle", 0, busy);
    endtask
    initial begin
        #50000;
        err_total++;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 t_unsup;
        t_alu;
        t_rot;
        t_reset;
        t_move;
        t_ext;
        stop_test;
    end
endmodule // instr_decode_tb
